// ==== bench/irc_far_model.sv ====
/*
  far side: external reset circuit on a pulled-up reset wire and an
  irq source on the pulled-up irq pin.
  assumes: clk is the e-clock; extReq is a one-cycle pulse.
*/
`timescale 1ns/1ps

module irc_far_model #(
  parameter [7:0] HOLD = 8'h28
) (
  // clock
  input wire clk,
  // bench control
  input wire extReq,
  input wire irqDrive,
  // pins
  input wire resetPinOe,
  input wire resetPinOut,
  output wire resetPinIn,
  output wire irqPinN,
  output wire extBusy
);
  reg [7:0] holdCnt_q = 8'h0;
  always @(posedge clk) begin
    if (extReq) begin
      holdCnt_q <= HOLD;
    end else if (holdCnt_q != 8'h0) begin
      holdCnt_q <= holdCnt_q - 8'h1;
    end
  end
  assign extBusy = holdCnt_q != 8'h0;
  // wired line, pullup when nobody pulls
  assign resetPinIn = !extBusy && !(resetPinOe && !resetPinOut);
  assign irqPinN = !irqDrive;
endmodule // irc_far_model

// ==== bench/irc_top_asserts.sv ====
/*
  checker for the interrupt and reset control top.
  assumes: bound to irc_top, sees its ports only.
*/
`timescale 1ns/1ps

module irc_checker (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // watched ports
  input wire resetPinOe,
  input wire cpuResetN,
  input wire [15:0] cpuSp,
  input wire rtiExec,
  input wire [7:0] condition_codes,
  input wire flushQ,
  input wire stackWr,
  input wire [15:0] stackAddr,
  input wire stackByte,
  input wire vecFetch,
  input wire [15:0] vecAddr,
  input wire spLoad,
  input wire [15:0] spValue,
  input wire resume,
  input wire [1:0] resetCause
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // length of the reset pin drive
  reg [5:0] oeCnt_q;
  wire [5:0] oeCnt_d = resetPinOe ? oeCnt_q + 6'h1 : 6'h0;
  always @(posedge clk) oeCnt_q <= rst_n ? oeCnt_d : 6'h0;
  sequence s_stack;
    stackWr && !stackByte && stackAddr == $past(cpuSp, 2) - 16'h2 ##1
    stackWr && stackAddr == $past(cpuSp, 3) - 16'h4 ##1
    stackWr && stackAddr == $past(cpuSp, 4) - 16'h6 ##1
    stackWr && stackAddr == $past(cpuSp, 5) - 16'h8 ##1
    stackWr && stackByte && stackAddr == $past(cpuSp, 6) - 16'h9;
  endsequence
  sequence s_vec;
    vecFetch ##[0:1] condition_codes[4];
  endsequence
  sequence s_hold8;
    !cpuResetN [*8];
  endsequence
  AST_STACK: assert property (flushQ |=> s_stack ##1 s_vec)
    else $error("stacking sequence wrong");
  AST_CHAIN: assert property (spLoad |-> spValue == $past(cpuSp) - 16'h9 ##1 s_vec)
    else $error("chained return wrong");
  AST_RTI_ONE: assert property (rtiExec |=> spLoad != resume)
    else $error("return neither chained nor resumed");
  AST_RST_VEC: assert property ($rose(cpuResetN) |-> ##[0:2] vecFetch && vecAddr ==
    (resetCause == 2'h2 ? 16'hfffa : resetCause == 2'h1 ? 16'hfffc : 16'hfffe))
    else $error("reset vector wrong");
  AST_OE_CNT: assert property ($fell(resetPinOe) |-> oeCnt_q inside {[16:17]})
    else $error("reset pin drive length wrong");
  AST_OE_WAIT: assert property ($fell(resetPinOe) |-> s_hold8)
    else $error("cpu left reset before pin sample");
  AST_OE_CPU: assert property (resetPinOe |-> !cpuResetN)
    else $error("cpu running while pin driven");
  AST_CPU_RST: assert property (disable iff (1'b0) !rst_n |-> !cpuResetN)
    else $error("cpu not held in reset");
  AST_CCR_RST: assert property (disable iff (1'b0) !rst_n |=> condition_codes == 8'hd0)
    else $error("condition codes not at reset value");
endmodule // irc_checker

bind irc_top irc_checker u_chk (.clk, .rst_n, .resetPinOe, .cpuResetN, .cpuSp, .rtiExec,
  .condition_codes, .flushQ, .stackWr, .stackAddr, .stackByte, .vecFetch, .vecAddr, .spLoad, .spValue,
  .resume, .resetCause);

// ==== bench/test_interrupt_reset_control.sv ====
/*
  self-checking bench of the interrupt and reset control block.
  assumes: 200 MHz e-clock; far side from irc_far_model.
*/
`timescale 1ns/1ps

module test_interrupt_reset_control;
  localparam int STOPD = 16;
  reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [9:0] paddr = 10'h0;
  reg [31:0] pwdata = 32'h0;
  reg xirqPinN = 1'b1, debugPinIn = 1'b1, modePinHigh = 1'b0, modePinLow = 1'b0;
  reg clkFailDet = 1'b0, stopExit = 1'b0, instrDone = 1'b0, ccrWr = 1'b0, rtiExec = 1'b0;
  reg extReq = 1'b0, irqDrive = 1'b0;
  reg [15:0] periphIrq = 16'h0, cpuSp = 16'h0, retAddr = 16'h0, regY = 16'h0;
  reg [15:0] regX = 16'h0, regD = 16'h0;
  reg [7:0] ccrWrData = 8'h0, rtiCcr = 8'h0;
  wire [31:0] prdata;
  wire [15:0] stackAddr, stackData, vecAddr, spValue;
  wire [7:0] condition_codes;
  wire [1:0] resetCause;
  wire pready, pslverr, resetPinIn, resetPinOut, resetPinOe, stopWake, cpuResetN, flushQ;
  wire stackWr, stackByte, vecFetch, spLoad, resume, irqPinN, extBusy;
  int n_fail = 0;
  int num_checks = 0;
  int nFlush = 0;
  int expF = 0;
  int unsigned seed = 39;
  logic [31:0] expV[$];
  logic [31:0] expS[$];
  logic [7:0] cfgM;
  logic lastErr, lockE, lockD, first, spec = 1'b0;

  irc_top #(.WD_BASE(24'h4000), .RTI_BASE(24'h8), .STOP_DLY(13'h10)) u_dut (.clk, .rst_n,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irqPinN,
    .xirqPinN, .resetPinIn, .resetPinOut, .resetPinOe, .debugPinIn, .modePinHigh,
    .modePinLow, .clkFailDet, .stopExit, .stopWake, .periphIrq, .cpuResetN, .instrDone,
    .cpuSp, .retAddr, .regY, .regX, .regD, .ccrWr, .ccrWrData, .rtiExec, .rtiCcr, .condition_codes,
    .flushQ, .stackWr, .stackAddr, .stackData, .stackByte, .vecFetch, .vecAddr, .spLoad,
    .spValue, .resume, .resetCause);
  irc_far_model u_far (.clk, .extReq, .irqDrive, .resetPinOe, .resetPinOut, .resetPinIn,
    .irqPinN, .extBusy);

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // results of stacking and vector fetch against the bench model
  always @(posedge clk) begin
    if (flushQ === 1'b1) nFlush++;
    if (stackWr === 1'b1) chk(stackByte ? {16'h0, stackAddr} : {stackAddr, stackData},
      expS.size() ? expS.pop_front() : 32'hdead);
    if (vecFetch === 1'b1) chk(vecAddr, expV.size() ? expV.pop_front() : 32'h1);
  end

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    apb(1'b1, idx, wd, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    apb(1'b0, idx, 8'h0, d);
    chk(d, {24'h0, exp});
  endtask

  // config write with the write-once and special-mode model
  task automatic cfg(input logic [7:0] wd);
    if (spec) cfgM = {first ? cfgM[7] : wd[7], wd[6:5], 5'h0};
    else cfgM = {lockE ? cfgM[7] : wd[7], wd[6], lockD ? cfgM[5] : wd[5], 5'h0};
    lockE = 1'b1;
    lockD = 1'b1;
    first = 1'b0;
    wr(8'h1e, wd);
    rdchk(8'h1e, cfgM);
  endtask

  task automatic boot(input logic [15:0] v, input logic [1:0] c);
    int n;
    expV.push_back({16'h0, v});
    cfgM = 8'h60;
    lockE = 1'b0;
    lockD = 1'b0;
    first = 1'b1;
    n = 0;
    repeat (4) @(posedge clk);
    while (cpuResetN !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) n_fail++;
    repeat (3) @(posedge clk);
    chk(resetCause, c);
  endtask

  task automatic stopchk(input int lo, input int hi);
    int n;
    @(posedge clk);
    stopExit <= 1'b1;
    @(posedge clk);
    stopExit <= 1'b0;
    n = 0;
    while (stopWake !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic setccr(input logic [7:0] v);
    @(posedge clk);
    ccrWrData <= v;
    ccrWr <= 1'b1;
    @(posedge clk);
    ccrWr <= 1'b0;
  endtask

  task automatic step();
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic take(input logic [15:0] v);
    logic [15:0] r [5];
    foreach (r[i]) r[i] = xs();
    @(posedge clk);
    cpuSp <= r[0];
    retAddr <= r[1];
    regY <= r[2];
    regX <= r[3];
    regD <= r[4];
    for (int i = 1; i < 5; i++) expS.push_back({r[0] - 16'(2 * i), r[i]});
    expS.push_back({16'h0, r[0] - 16'h9});
    expV.push_back({16'h0, v});
    expF++;
    step();
  endtask

  task automatic return_from_interrupt(input logic [7:0] c);
    @(posedge clk);
    cpuSp <= xs();
    rtiCcr <= c;
    rtiExec <= 1'b1;
    @(posedge clk);
    rtiExec <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    boot(16'hfffe, 2'h0);
    chk({24'h0, condition_codes}, 32'hd0);
    rdchk(8'h1e, 8'h60);
    rdchk(8'h1f, 8'hf2);
    rdchk(8'h21, 8'h01);
    rdchk(8'h22, 8'h00);
    rdchk(8'h23, 8'h00);
    rdchk(8'h24, 8'h80);
    rdchk(8'h30, 8'h00);
    chk(lastErr, 1'b1);
    wr(8'h20, 8'h55);
    wr(8'h20, 8'haa);
    repeat (3) @(posedge clk);
    chk(cpuResetN, 1'b1);
    stopchk(STOPD - 1, STOPD + 3);
    wr(8'h1f, 8'he0);
    rdchk(8'h1f, 8'he0);
    cfg(8'h9f);
    cfg(8'h60);
    stopchk(0, 3);
    setccr(8'h00);
    wr(8'h1f, 8'hf0);
    rdchk(8'h1f, 8'he0);
    @(posedge clk);
    periphIrq <= 16'h0081;
    irqDrive <= 1'b1;
    take(16'hffe0);
    periphIrq <= 16'h0;
    expV.push_back(32'hfff2);
    return_from_interrupt(8'h00);
    return_from_interrupt(8'h00);
    step();
    chk(nFlush, expF);
    cfg(8'h80);
    irqDrive <= 1'b0;
    @(posedge clk);
    irqDrive <= 1'b1;
    step();
    chk(nFlush, expF);
    wr(8'h20, 8'h55);
    wr(8'h20, 8'h12);
    boot(16'hfffa, 2'h2);
    rdchk(8'h1e, 8'h60);
    rdchk(8'h24, 8'h82);
    wr(8'h1f, 8'hf8);
    rdchk(8'h1f, 8'hf8);
    periphIrq <= 16'h0001;
    setccr(8'h00);
    take(16'hfff2);
    periphIrq <= 16'h0;
    expV.push_back(32'hfff2);
    return_from_interrupt(8'h00);
    irqDrive <= 1'b0;
    return_from_interrupt(8'h00);
    spec = 1'b1;
    debugPinIn <= 1'b0;
    wr(8'h21, 8'h41);
    clkFailDet <= 1'b1;
    boot(16'hfffc, 2'h1);
    clkFailDet <= 1'b0;
    rdchk(8'h21, 8'h01);
    rdchk(8'h24, 8'h01);
    cfg(8'h80);
    cfg(8'h80);
    cfg(8'h20);
    spec = 1'b0;
    debugPinIn <= 1'b1;
    extReq <= 1'b1;
    @(posedge clk);
    extReq <= 1'b0;
    boot(16'hfffe, 2'h0);
    rdchk(8'h24, 8'h80);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    boot(16'hfffe, 2'h0);
    chk(expV.size(), 0);
    chk(expS.size(), 0);
    end_sim();
  end
endmodule // test_interrupt_reset_control

// ==== hdl/irc_regs.vh ====
/*
  register indices, field positions, reset values and timing counts
  of the interrupt and reset control block.
  assumes: included by bare name; byte address is four times the index.
*/
`ifndef IRC_REGS_VH
`define IRC_REGS_VH

// register indices (byte address = index * 4)
`define IRC_IDX_INTCFG 8'h1e
`define IRC_IDX_PROMO 8'h1f
`define IRC_IDX_WDSVC 8'h20
`define IRC_IDX_WDCTL 8'h21
`define IRC_IDX_RTICTL 8'h22
`define IRC_IDX_RTIFLG 8'h23
`define IRC_IDX_STAT 8'h24

// interrupt_pin_config fields and reset, and the priority select reset
`define IRC_INT_EDGE 7
`define IRC_INT_CONN 6
`define IRC_INT_WAIT 5
`define IRC_INTCFG_RST 8'h60
`define IRC_HIGHEST_PRIORITY_SELECT_RST 8'hf2

// watchdog
`define IRC_WD_KEY1 8'h55
`define IRC_WD_KEY2 8'haa
`define IRC_WD_RATE_RST 3'h1
`define IRC_WD_CME 6
`define IRC_WD_BASE_CYC 1024

// real-time interrupt
`define IRC_TICK_EN 7
`define IRC_TICK_FLAG 7
`define IRC_TICK_BASE_CYC 1024

// condition code bits and reset value
`define IRC_CC_S 7
`define IRC_CC_X 6
`define IRC_CC_I 4
`define IRC_CC_RST 8'hd0

// vectors
`define IRC_VEC_RESET 16'hfffe
`define IRC_VEC_CLKMON 16'hfffc
`define IRC_VEC_WDOG 16'hfffa
`define IRC_VEC_NMI 8'hf4
`define IRC_VEC_IRQ 8'hf2

// reset causes
`define IRC_CAUSE_EXT 2'h0
`define IRC_CAUSE_CM 2'h1
`define IRC_CAUSE_WD 2'h2

// timing in e-clock cycles
`define IRC_RST_DRIVE_CYC 16
`define IRC_RST_SAMPLE_CYC 8
`define IRC_STOP_DLY_CYC 4096

`endif

// ==== hdl/irc_reset_seq.v ====
/*
  reset pin sequencer: drives the reset pin low, releases it,
  samples it and reports the reset cause.
  assumes: clk is the e-clock; reset pin input synchronous to clk.
*/
`timescale 1ns/1ps
`include "irc_regs.vh"

module irc_reset_seq #(
  parameter DRIVE_CYC = `IRC_RST_DRIVE_CYC,
  parameter SAMPLE_CYC = `IRC_RST_SAMPLE_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // internal reset request
  input wire intReq,
  input wire intSrcCm,
  // reset pin
  input wire resetPinIn,
  output wire resetPinOut,
  output wire resetPinOe,
  // status
  output wire busy,
  output reg done,
  output reg [1:0] cause
);

  localparam S_IDLE = 4'b0001;
  localparam S_DRIVE = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_HOLD = 4'b1000;

  reg [3:0] state_q;
  reg [4:0] cnt_q;
  reg [1:0] src_q;

  assign resetPinOut = 1'b0;
  assign resetPinOe = state_q[1];
  assign busy = ~state_q[0];

  always @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      state_q <= S_DRIVE;
      cnt_q <= 5'h00;
      src_q <= `IRC_CAUSE_EXT;
      cause <= `IRC_CAUSE_EXT;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= 5'h00;
          if (intReq) begin
            state_q <= S_DRIVE;
            src_q <= intSrcCm ? `IRC_CAUSE_CM : `IRC_CAUSE_WD;
          end else if (!resetPinIn) begin
            state_q <= S_DRIVE;
            src_q <= `IRC_CAUSE_EXT;
          end
        end
        S_DRIVE: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == DRIVE_CYC - 1) begin
            state_q <= S_WAIT;
            cnt_q <= 5'h00;
          end
        end
        S_WAIT: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SAMPLE_CYC - 1) begin
            if (!resetPinIn) begin
              cause <= `IRC_CAUSE_EXT;
              state_q <= S_HOLD;
            end else begin
              cause <= src_q;
              done <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          if (resetPinIn) begin
            done <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // irc_reset_seq

// ==== hdl/irc_top.v ====
/*
  interrupt and reset control: pin config, priority promotion,
  reset sequencing, watchdog, clock monitor, rti timer and the
  exception entry and return sequencer, with an apb register slave.
  assumes: clk is the e-clock; all inputs synchronous to clk;
  the cpu holds sp and register values stable while stacking.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "irc_regs.vh"

module irc_top #(
  parameter NPER = 16,
  parameter WD_W = 24,
  parameter [WD_W-1:0] WD_BASE = `IRC_WD_BASE_CYC,
  parameter [WD_W-1:0] RTI_BASE = `IRC_TICK_BASE_CYC,
  parameter [12:0] STOP_DLY = `IRC_STOP_DLY_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire [9:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // pins
  input wire irqPinN,
  input wire xirqPinN,
  input wire resetPinIn,
  output wire resetPinOut,
  output wire resetPinOe,
  input wire debugPinIn,
  input wire modePinHigh,
  input wire modePinLow,
  // clock and stop
  input wire clkFailDet,
  input wire stopExit,
  output reg stopWake,
  // peripheral requests, index 0 is vector ee
  input wire [NPER-1:0] periphIrq,
  // cpu side
  output wire cpuResetN,
  input wire instrDone,
  input wire [15:0] cpuSp,
  input wire [15:0] retAddr,
  input wire [15:0] regY,
  input wire [15:0] regX,
  input wire [15:0] regD,
  input wire ccrWr,
  input wire [7:0] ccrWrData,
  input wire rtiExec,
  input wire [7:0] rtiCcr,
  output reg [7:0] condition_codes,
  output reg flushQ,
  output reg stackWr,
  output reg [15:0] stackAddr,
  output reg [15:0] stackData,
  output reg stackByte,
  output reg vecFetch,
  output reg [15:0] vecAddr,
  output reg spLoad,
  output reg [15:0] spValue,
  output reg resume,
  output reg [1:0] resetCause
);

  localparam NSRC = NPER + 2;
  localparam [7:0] VEC_LOW = 8'hf2 - 2 * (NSRC - 1);
  localparam X_IDLE = 3'b001;
  localparam X_STACK = 3'b010;
  localparam X_VEC = 3'b100;

  wire rsBusy;
  wire rsDone;
  wire [1:0] rsCause;
  reg rstReq_q;
  reg rstCm_q;
  wire sysRst = ~rst_n | rsBusy;

  irc_reset_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .intReq(rstReq_q),
    .intSrcCm(rstCm_q),
    .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe),
    .busy(rsBusy),
    .done(rsDone),
    .cause(rsCause)
  );

  assign cpuResetN = ~(~rst_n | rsBusy | rstReq_q);

  // apb decode
  wire [7:0] idx = paddr[9:2];
  wire hitCfg = idx == `IRC_IDX_INTCFG;
  wire hitPri = idx == `IRC_IDX_PROMO;
  wire hitSvc = idx == `IRC_IDX_WDSVC;
  wire hitWdc = idx == `IRC_IDX_WDCTL;
  wire hitRtc = idx == `IRC_IDX_RTICTL;
  wire hitRtf = idx == `IRC_IDX_RTIFLG;
  wire hitSta = idx == `IRC_IDX_STAT;
  wire hitAny = hitCfg | hitPri | hitSvc | hitWdc | hitRtc | hitRtf | hitSta;
  wire acc = psel & penable;
  wire wr = acc & pwrite & hitAny;
  wire [7:0] wd = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = acc & ~hitAny;

  // mode bits
  reg normalMode_q;
  reg modeH_q;
  reg modeL_q;
  wire special = ~normalMode_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      normalMode_q <= 1'b1;
      modeH_q <= 1'b0;
      modeL_q <= 1'b0;
      resetCause <= `IRC_CAUSE_EXT;
    end else if (rsDone) begin
      normalMode_q <= debugPinIn;
      modeH_q <= modePinHigh;
      modeL_q <= modePinLow;
      resetCause <= rsCause;
    end
  end

  // configuration registers
  reg edge_q;
  reg conn_q;
  reg dly_q;
  reg edgeWr_q;
  reg dlyWr_q;
  reg [7:0] highest_priority_select_q;
  reg [2:0] wdRate_q;
  reg cme_q;
  reg rtie_q;
  reg [2:0] rtiRate_q;

  always @(posedge clk) begin
    if (sysRst) begin
      edge_q <= 1'b0;
      conn_q <= 1'b1;
      dly_q <= 1'b1;
      edgeWr_q <= 1'b0;
      dlyWr_q <= 1'b0;
      highest_priority_select_q <= `IRC_HIGHEST_PRIORITY_SELECT_RST;
      wdRate_q <= `IRC_WD_RATE_RST;
      cme_q <= 1'b0;
      rtie_q <= 1'b0;
      rtiRate_q <= 3'h0;
    end else begin
      if (wr && hitCfg) begin
        edgeWr_q <= 1'b1;
        if (special ? edgeWr_q : ~edgeWr_q)
          edge_q <= wd[`IRC_INT_EDGE];
        conn_q <= wd[`IRC_INT_CONN];
        if (special | ~dlyWr_q) begin
          dly_q <= wd[`IRC_INT_WAIT];
          dlyWr_q <= 1'b1;
        end
      end
      if (wr && hitPri && condition_codes[`IRC_CC_I])
        highest_priority_select_q <= wd;
      if (wr && hitWdc) begin
        wdRate_q <= wd[2:0];
        cme_q <= wd[`IRC_WD_CME];
      end
      if (wr && hitRtc) begin
        rtie_q <= wd[`IRC_TICK_EN];
        rtiRate_q <= wd[2:0];
      end
    end
  end

  // real-time interrupt timer
  reg [WD_W-1:0] rtiCnt_q;
  reg rtiFlag_q;
  wire [WD_W-1:0] rtiLim = RTI_BASE << rtiRate_q;
  wire rtiTick = (rtiRate_q != 3'h0) && (rtiCnt_q == rtiLim - 1'b1);

  always @(posedge clk) begin
    if (sysRst) begin
      rtiCnt_q <= {WD_W{1'b0}};
      rtiFlag_q <= 1'b0;
    end else begin
      rtiCnt_q <= (rtiTick || rtiRate_q == 3'h0) ? {WD_W{1'b0}} : rtiCnt_q + 1'b1;
      if (rtiTick)
        rtiFlag_q <= 1'b1;
      else if (wr && hitRtf && wd[`IRC_TICK_FLAG])
        rtiFlag_q <= 1'b0;
    end
  end

  // watchdog and clock monitor
  reg [WD_W-1:0] wdCnt_q;
  reg wdArm_q;
  wire wdEn = wdRate_q != 3'h0;
  wire [WD_W-1:0] wdLim = WD_BASE << wdRate_q;
  wire svc = wr & hitSvc & wdEn;
  wire wdBad = svc & ~(wd == `IRC_WD_KEY1 | (wd == `IRC_WD_KEY2 & wdArm_q));
  wire wdOut = wdEn & (wdCnt_q == wdLim - 1'b1);
  wire cmFail = cme_q & clkFailDet;

  always @(posedge clk) begin
    if (sysRst) begin
      wdCnt_q <= {WD_W{1'b0}};
      wdArm_q <= 1'b0;
      rstReq_q <= 1'b0;
      rstCm_q <= 1'b0;
    end else begin
      rstReq_q <= wdBad | wdOut | cmFail;
      rstCm_q <= cmFail;
      if (!wdEn)
        wdCnt_q <= {WD_W{1'b0}};
      else if (svc && wd == `IRC_WD_KEY2 && wdArm_q)
        wdCnt_q <= {WD_W{1'b0}};
      else
        wdCnt_q <= wdCnt_q + 1'b1;
      if (svc)
        wdArm_q <= wd == `IRC_WD_KEY1;
    end
  end

  // stop exit delay
  reg [12:0] stopCnt_q;
  reg stopBusy_q;

  always @(posedge clk) begin
    stopWake <= 1'b0;
    if (sysRst) begin
      stopCnt_q <= 13'h0000;
      stopBusy_q <= 1'b0;
    end else if (stopBusy_q) begin
      stopCnt_q <= stopCnt_q + 13'h0001;
      if (stopCnt_q == STOP_DLY - 1'b1) begin
        stopBusy_q <= 1'b0;
        stopWake <= 1'b1;
      end
    end else if (stopExit) begin
      stopCnt_q <= 13'h0000;
      if (dly_q)
        stopBusy_q <= 1'b1;
      else
        stopWake <= 1'b1;
    end
  end

  // irq pin and maskable arbitration
  reg irqPrev_q;
  reg edgeLat_q;
  wire irqReq = conn_q & (edge_q ? edgeLat_q : ~irqPinN);
  wire [NSRC-1:0] src = {periphIrq, rtiFlag_q & rtie_q, irqReq};
  wire priOk = highest_priority_select_q <= `IRC_VEC_IRQ && highest_priority_select_q >= VEC_LOW && !highest_priority_select_q[0];
  wire [7:0] priDiff = `IRC_VEC_IRQ - highest_priority_select_q;
  wire [4:0] pIdx = priOk ? priDiff[5:1] : 5'h00;
  reg [4:0] win;
  integer k;

  always @* begin
    win = 5'h00;
    for (k = NSRC - 1; k >= 0; k = k - 1)
      if (src[k])
        win = k[4:0];
    if (src[pIdx])
      win = pIdx;
  end

  wire anyMask = |src;
  wire [7:0] winVec = `IRC_VEC_IRQ - {2'b00, win, 1'b0};
  wire xirqReq = ~xirqPinN;

  // exception sequencer
  reg [2:0] xs_q;
  reg [2:0] step_q;
  reg [15:0] sp_q;
  reg [7:0] vecSel_q;
  reg setX_q;
  wire xIdle = xs_q[0];
  wire pendNow = (xirqReq & ~condition_codes[`IRC_CC_X]) | (anyMask & ~condition_codes[`IRC_CC_I]);
  wire take = instrDone & xIdle & pendNow & cpuResetN & ~rtiExec;
  wire chain = (xirqReq & ~rtiCcr[`IRC_CC_X]) | (anyMask & ~rtiCcr[`IRC_CC_I]);
  wire [7:0] selVec = (xirqReq & ~condition_codes[`IRC_CC_X]) ? `IRC_VEC_NMI : winVec;
  wire [7:0] chVec = (xirqReq & ~rtiCcr[`IRC_CC_X]) ? `IRC_VEC_NMI : winVec;
  wire irqSvc = xs_q[2] & (vecSel_q == `IRC_VEC_IRQ);

  always @(posedge clk) begin
    if (sysRst) begin
      irqPrev_q <= 1'b1;
      edgeLat_q <= 1'b0;
    end else begin
      irqPrev_q <= irqPinN;
      if (conn_q & edge_q & irqPrev_q & ~irqPinN)
        edgeLat_q <= 1'b1;
      else if (irqSvc)
        edgeLat_q <= 1'b0;
    end
  end

  always @(posedge clk) begin
    flushQ <= 1'b0;
    stackWr <= 1'b0;
    stackByte <= 1'b0;
    vecFetch <= 1'b0;
    spLoad <= 1'b0;
    resume <= 1'b0;
    if (sysRst) begin
      xs_q <= X_IDLE;
      step_q <= 3'h0;
      sp_q <= 16'h0000;
      vecSel_q <= 8'h00;
      setX_q <= 1'b0;
      stackAddr <= 16'h0000;
      stackData <= 16'h0000;
      vecAddr <= 16'h0000;
      spValue <= 16'h0000;
    end else begin
      if (rsDone) begin
        vecFetch <= 1'b1;
        vecAddr <= (resetCause == `IRC_CAUSE_CM) ? `IRC_VEC_CLKMON : `IRC_VEC_RESET;
        if (rsCause == `IRC_CAUSE_CM)
          vecAddr <= `IRC_VEC_CLKMON;
        else if (rsCause == `IRC_CAUSE_WD)
          vecAddr <= `IRC_VEC_WDOG;
        else
          vecAddr <= `IRC_VEC_RESET;
      end
      case (xs_q)
        X_IDLE: begin
          step_q <= 3'h0;
          if (take) begin
            flushQ <= 1'b1;
            sp_q <= cpuSp;
            vecSel_q <= selVec;
            setX_q <= xirqReq & ~condition_codes[`IRC_CC_X];
            xs_q <= X_STACK;
          end else if (rtiExec) begin
            if (chain) begin
              spLoad <= 1'b1;
              spValue <= cpuSp - 16'h0009;
              vecSel_q <= chVec;
              setX_q <= xirqReq & ~rtiCcr[`IRC_CC_X];
              xs_q <= X_VEC;
            end else
              resume <= 1'b1;
          end
        end
        X_STACK: begin
          stackWr <= 1'b1;
          step_q <= step_q + 3'h1;
          case (step_q)
            3'h0: begin
              stackAddr <= sp_q - 16'h0002;
              stackData <= retAddr;
            end
            3'h1: begin
              stackAddr <= sp_q - 16'h0004;
              stackData <= regY;
            end
            3'h2: begin
              stackAddr <= sp_q - 16'h0006;
              stackData <= regX;
            end
            3'h3: begin
              stackAddr <= sp_q - 16'h0008;
              stackData <= regD;
            end
            default: begin
              stackAddr <= sp_q - 16'h0009;
              stackData <= {8'h00, condition_codes};
              stackByte <= 1'b1;
              xs_q <= X_VEC;
            end
          endcase
        end
        X_VEC: begin
          vecFetch <= 1'b1;
          vecAddr <= {8'hff, vecSel_q};
          xs_q <= X_IDLE;
        end
        default: xs_q <= X_IDLE;
      endcase
    end
  end

  // condition codes
  always @(posedge clk) begin
    if (sysRst)
      condition_codes <= `IRC_CC_RST;
    else if (xs_q[2]) begin
      condition_codes[`IRC_CC_I] <= 1'b1;
      if (setX_q)
        condition_codes[`IRC_CC_X] <= 1'b1;
    end else if (xIdle && rtiExec)
      condition_codes <= rtiCcr;
    else if (ccrWr)
      condition_codes <= ccrWrData;
  end

  // read data captured in the setup phase
  always @(posedge clk) begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (hitCfg)
        prdata[7:0] <= {edge_q, conn_q, dly_q, 5'h00};
      else if (hitPri)
        prdata[7:0] <= highest_priority_select_q;
      else if (hitWdc)
        prdata[7:0] <= {1'b0, cme_q, 3'h0, wdRate_q};
      else if (hitRtc)
        prdata[7:0] <= {rtie_q, 4'h0, rtiRate_q};
      else if (hitRtf)
        prdata[7:0] <= {rtiFlag_q, 7'h00};
      else if (hitSta)
        prdata[7:0] <= {normalMode_q, modeH_q, modeL_q, 3'h0, resetCause};
    end
  end

endmodule // irc_top
